// >>> core/psw_sleep_wake.sv
// Operation
// R1 - Sleep command is encoded for at least 64 bits unless aborted.
// R2 - Wake-request command is encoded for at least 64 bits unless aborted.
// R3 - Every transmitted wake pulse lasts 1 ms within 0.3 ms.
// R4 - Wake pulse is made of training codes in training transmit mode.
// R5 - Scrambler bit 1 carries data, inverted sleep command, or plain.
// R6 - Scrambler bit 0 carries data, inverted wake command, or plain.
// R7 - Activity flag clears on zero symbol runs, sets otherwise, within 1 us.
// R8 - Sleep command received flag rises only after a full command.
// R9 - Wake-request received flag rises only after a full command.
// R10 - Wake pulse received flag rises when partner pulses are sensed.
// R11 - Sleep command sending is high while the sleep bits are emitted.
// R12 - Sleep command sent rises only after 64 bits are transmitted.
// R13 - Local control raises doze and rouse requests.
// R14 - Reject request is honoured only in the acknowledge wait state.
// R15 - Handshake failed rises when the partner aborts the handshake; the code raises it only when the handshake timer expires.
// R16 - Inhibit output is high while supply shutdown must be inhibited.
// R17 - Sleep output tells transceiver control to stop transmitting.
// R18 - Low power capable follows the sleep capability enable.
// R19 - Pulse qualify timer expires 1 ms after start.
// R20 - Acknowledge wait timer expires 8 ms after start.
// R21 - Handshake timer expiry without sleep leads to abort then normal.
// R22 - Handshake moves to quiet after sending and receiving sleep command.
// R23 - Quiet keeps transmitter silent, sleeps when activity is gone.
// R24 - Wake uses command when up, pulse when down, waits when training.
// R25 - Wake request during irreversible entry is stored and run in sleep.
// R26 - Timers count clock cycles with parameterised terminal counts.
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/100ps
module psw_sleep_wake #(
  parameter int PULSE_CNT = psw_pkg::PULSE_CYC,
  parameter int ACK_CNT = psw_pkg::ACK_CYC,
  parameter int SHAKE_CNT = psw_pkg::SHAKE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] sc,
  input wire logic [1:0] tx_data,
  input wire logic tx_enable,
  input wire logic [1:0] tx_mode,
  input wire logic rx_zero,
  input wire logic rx_cmd_sleep,
  input wire logic rx_cmd_rouse,
  input wire logic line_energy,
  output logic [1:0] sd,
  output logic wake_training_req,
  output logic sleep_cmd_sending,
  output logic sleep,
  output logic inhibit,
  output logic low_power_capable
);
  import psw_pkg::*;

  localparam logic [TMR_W-1:0] PULSE_T = TMR_W'(PULSE_CNT - 1);
  localparam logic [TMR_W-1:0] ACK_T = TMR_W'(ACK_CNT - 1);
  localparam logic [TMR_W-1:0] SHAKE_T = TMR_W'(SHAKE_CNT - 1);
  localparam logic [6:0] CMD_T = 7'(CMD_BITS);
  localparam logic [4:0] ZERO_T = 5'(ZERO_RUN);

  psw_state_e state, next_state;
  logic [3:0] ctrl;
  logic [4:0] evt;
  logic [2:0] ten_d;
  logic [TMR_W-1:0] tmr, pq_cnt, tp_cnt;
  logic [6:0] cmd_cnt, rs_cnt, rw_cnt;
  logic [4:0] zero_cnt;
  logic en_m, en_s;
  logic local_activity_seen;
  logic sleep_cmd_received, rouse_cmd_received, rouse_pulse_received;
  logic sleep_cmd_sent, rouse_sending, handshake_failed;
  logic rouse_pend;
  logic tmr_done, cmd_bit, rouse_bit, wr, rd_setup, in_map;
  logic local_doze_request, local_rouse_request, local_reject_request;

  assign wr = psel && penable && pwrite && ce;
  assign rd_setup = psel && !penable;
  assign in_map = paddr == OFF_CTRL || paddr == OFF_STAT
    || paddr == OFF_EVT;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !in_map;

  assign local_doze_request = ctrl[CTRL_DOZE]; // R13
  assign local_rouse_request = ctrl[CTRL_ROUSE] || rouse_pend; // R13
  assign local_reject_request = ctrl[CTRL_REJECT]
    && state == ST_ACK_WAIT; // R14
  assign low_power_capable = ctrl[CTRL_CAP]; // R18
  assign sleep_cmd_sending = state == ST_HANDSHAKE && tx_mode == MODE_N
    && !tmr_done; // R11
  assign sleep = state == ST_SLEEP; // R17
  assign inhibit = state != ST_SLEEP && state != ST_QUIET; // R16
  assign cmd_bit = !ten_d[2] && tx_mode == MODE_N;
  // The wake bit also needs send mode now, so a mode change stops it at once.
  assign rouse_bit = rouse_sending && local_rouse_request
    && tx_mode == MODE_N && !sleep_cmd_sending; // R6
  assign tmr_done = (state == ST_ACK_WAIT && tmr == ACK_T)
    || (state == ST_HANDSHAKE && tmr == SHAKE_T); // R20 R21 R26

  // Software sets request bits; hardware clears doze in handshake or without capability, rouse next cycle, reject outside acknowledge wait.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST;
    end else if (ce) begin
      if (state == ST_HANDSHAKE || !ctrl[CTRL_CAP])
        ctrl[CTRL_DOZE] <= 1'b0;
      if (state != ST_ACK_WAIT)
        ctrl[CTRL_REJECT] <= 1'b0;
      if (ctrl[CTRL_ROUSE])
        ctrl[CTRL_ROUSE] <= 1'b0;
      if (wr && paddr == OFF_CTRL) begin
        ctrl[CTRL_CAP] <= pwdata[CTRL_CAP];
        if (pwdata[CTRL_DOZE])
          ctrl[CTRL_DOZE] <= 1'b1;
        if (pwdata[CTRL_ROUSE])
          ctrl[CTRL_ROUSE] <= 1'b1;
        if (pwdata[CTRL_REJECT])
          ctrl[CTRL_REJECT] <= 1'b1;
      end
    end
  end

  // Read data is captured in the setup phase so it is a flop output.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (ce && rd_setup) begin
      case (paddr)
        OFF_CTRL: prdata <= {28'h0, ctrl};
        OFF_STAT: prdata <= {20'h0, rouse_pend, local_activity_seen,
          sleep, inhibit, sleep_cmd_sent, rouse_pulse_received,
          rouse_cmd_received, sleep_cmd_received, 1'b0, state};
        OFF_EVT: prdata <= {27'h0, evt};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // Sticky events: a set in the same cycle as a write-one clear wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt <= EVT_RST;
    end else if (ce) begin
      evt <= (evt & ~((wr && paddr == OFF_EVT) ? pwdata[4:0] : 5'h00))
        | {sleep_cmd_sent, handshake_failed, rouse_pulse_received,
           rouse_cmd_received, sleep_cmd_received};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_m <= 1'b0;
      en_s <= 1'b0;
    end else if (ce) begin
      en_m <= line_energy;
      en_s <= en_m;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ten_d <= 3'h0;
      sd <= 2'h0;
    end else if (ce) begin
      ten_d <= {ten_d[1:0], tx_enable};
      if (ten_d[2]) begin
        sd <= sc ^ tx_data; // R5 R6
      end else begin
        sd[1] <= sc[1] ^ (sleep_cmd_sending && !local_rouse_request); // R5 R1
        sd[0] <= sc[0] ^ rouse_bit; // R6 R2
      end
    end
  end

  // Bits of an outgoing command are counted only in idle symbols.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_cnt <= 7'h0;
      sleep_cmd_sent <= 1'b0;
      rouse_sending <= 1'b0;
    end else if (ce) begin
      if (state == ST_NORMAL && !rouse_sending && local_rouse_request
          && tx_mode == MODE_N)
        rouse_sending <= 1'b1; // R24
      else if (rouse_sending && (cmd_cnt >= CMD_T || tx_mode != MODE_N))
        rouse_sending <= 1'b0; // R2
      if (!sleep_cmd_sending && !rouse_sending) begin
        cmd_cnt <= 7'h0;
        sleep_cmd_sent <= 1'b0;
      end else if (cmd_bit && cmd_cnt < CMD_T) begin
        cmd_cnt <= cmd_cnt + 7'h1;
      end else if (sleep_cmd_sending && cmd_cnt >= CMD_T) begin
        sleep_cmd_sent <= 1'b1; // R12 R1
      end
    end
  end

  // Received commands count consecutive flagged symbols.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rs_cnt <= 7'h0;
      rw_cnt <= 7'h0;
      sleep_cmd_received <= 1'b0;
      rouse_cmd_received <= 1'b0;
    end else if (ce) begin
      rs_cnt <= rx_cmd_sleep ? (rs_cnt < CMD_T ? rs_cnt + 7'h1 : rs_cnt)
        : 7'h0;
      rw_cnt <= rx_cmd_rouse ? (rw_cnt < CMD_T ? rw_cnt + 7'h1 : rw_cnt)
        : 7'h0;
      if (rs_cnt == CMD_T)
        sleep_cmd_received <= 1'b1; // R8
      else if (next_state == ST_NORMAL && state != ST_NORMAL)
        sleep_cmd_received <= 1'b0;
      rouse_cmd_received <= rw_cnt == CMD_T; // R9
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_cnt <= 5'h0;
      local_activity_seen <= 1'b1;
    end else if (ce) begin
      if (!rx_zero) begin
        zero_cnt <= 5'h0;
        local_activity_seen <= 1'b1; // R7
      end else if (zero_cnt < ZERO_T) begin
        zero_cnt <= zero_cnt + 5'h1;
      end else begin
        local_activity_seen <= 1'b0; // R7
      end
    end
  end

  // Energy detection is only armed in sleep, so quiet cannot self-wake.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pq_cnt <= '0;
      rouse_pulse_received <= 1'b0;
    end else if (ce) begin
      rouse_pulse_received <= 1'b0;
      if (state != ST_SLEEP || !en_s) begin
        pq_cnt <= '0;
      end else if (pq_cnt == PULSE_T) begin
        pq_cnt <= '0;
        rouse_pulse_received <= 1'b1; // R10 R19
      end else begin
        pq_cnt <= pq_cnt + 1'b1; // R19 R26
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tp_cnt <= '0;
      wake_training_req <= 1'b0;
    end else if (ce) begin
      if (!wake_training_req) begin
        tp_cnt <= '0;
        if (state == ST_NORMAL && local_rouse_request && tx_mode == MODE_Z)
          wake_training_req <= 1'b1; // R4 R24
      end else if (tp_cnt == PULSE_T) begin
        wake_training_req <= 1'b0; // R3
      end else begin
        tp_cnt <= tp_cnt + 1'b1; // R3 R26
      end
    end
  end

  // A wake request stays pending until a command or pulse carries it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rouse_pend <= 1'b0;
    end else if (ce) begin
      if (ctrl[CTRL_ROUSE])
        rouse_pend <= 1'b1; // R25
      else if ((rouse_sending && cmd_cnt >= CMD_T)
          || (wake_training_req && tp_cnt == PULSE_T))
        rouse_pend <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr <= '0;
    end else if (ce) begin
      if (next_state != state)
        tmr <= '0;
      else if (state == ST_ACK_WAIT || state == ST_HANDSHAKE)
        tmr <= tmr + 1'b1; // R20 R21 R26
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      handshake_failed <= 1'b0;
    end else if (ce) begin
      handshake_failed <= state == ST_HANDSHAKE && tmr_done; // R15
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_NORMAL: begin
        if (ctrl[CTRL_CAP] && !local_rouse_request && tx_mode == MODE_N) begin
          if (local_doze_request)
            next_state = ST_HANDSHAKE;
          else if (sleep_cmd_received)
            next_state = ST_ACK_WAIT;
        end
      end
      ST_ACK_WAIT: begin
        if (local_reject_request || local_rouse_request)
          next_state = ST_NORMAL; // R14
        else if (tmr_done)
          next_state = ST_HANDSHAKE; // R20
      end
      ST_HANDSHAKE: begin
        if (sleep_cmd_sent && sleep_cmd_received)
          next_state = ST_QUIET; // R22
        else if (tmr_done)
          next_state = ST_ABORT; // R21
        else if (local_rouse_request || rouse_cmd_received)
          next_state = ST_NORMAL;
      end
      ST_QUIET: begin
        if (!local_activity_seen)
          next_state = ST_SLEEP; // R23
      end
      ST_ABORT: next_state = ST_NORMAL; // R21
      ST_SLEEP: begin
        if (local_rouse_request || rouse_pulse_received)
          next_state = ST_NORMAL; // R25
      end
      default: next_state = ST_NORMAL;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      state <= ST_NORMAL;
    else if (ce)
      state <= next_state;
  end

  a_sd_data: assert property (@(posedge pclk) disable iff (!presetn) // R5
    ce && ten_d[2] |=> sd == $past(sc ^ tx_data))
    else $error("data symbol not scrambled with data");
  a_sd_sleep_cmd: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !ten_d[2] && sleep_cmd_sending && !local_rouse_request // R5
    |=> sd[1] == !$past(sc[1]))
    else $error("sleep command bit not inverted");
  a_sd_wake_cmd: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !ten_d[2] && rouse_sending && !sleep_cmd_sending // R6
    && local_rouse_request && tx_mode == MODE_N
    |=> sd[0] == !$past(sc[0]))
    else $error("wake command bit not inverted");
  a_sd_plain: assert property (@(posedge pclk) disable iff (!presetn) // R5
    ce && !ten_d[2] && tx_mode != MODE_N |=> sd == $past(sc))
    else $error("idle symbol not plain outside send mode");
  a_sent_full: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(sleep_cmd_sent) |-> cmd_cnt == CMD_T) // R12
    else $error("sleep command sent before 64 bits");
  a_wake_cmd_len: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(rouse_sending) && $past(tx_mode) == MODE_N // R2
    |-> $past(cmd_cnt) >= CMD_T)
    else $error("wake command shorter than 64 bits");
  a_pulse_len: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(wake_training_req) |-> $past(tp_cnt) == PULSE_T) // R3
    else $error("wake pulse length wrong");
  a_shake_abort: assert property (@(posedge pclk) disable iff (!presetn)
    ce && state == ST_HANDSHAKE && tmr_done // R21
    && !(sleep_cmd_sent && sleep_cmd_received)
    |=> state == ST_ABORT ##1 state == ST_NORMAL || !ce)
    else $error("handshake timeout did not abort");
  a_quiet_sleep: assert property (@(posedge pclk) disable iff (!presetn)
    ce && state == ST_QUIET && !local_activity_seen // R23
    |=> state == ST_SLEEP && sleep && !inhibit)
    else $error("quiet did not enter sleep");
  a_act_clear: assert property (@(posedge pclk) disable iff (!presetn)
    ce && rx_zero [*8] ##1 ce && rx_zero [*8] ##1 ce && rx_zero [*2] // R7
    |=> !local_activity_seen)
    else $error("activity not cleared within 1 us");
endmodule // psw_sleep_wake

// >>> core/psw_pkg.sv
package psw_pkg;
  localparam int CLK_NS = 50;
  localparam int PULSE_US = 1000;
  localparam int ACK_US = 8000;
  localparam int SHAKE_US = 16000;
  localparam int ACT_NS = 1000;
  localparam int PULSE_CYC = PULSE_US * 1000 / CLK_NS;
  localparam int ACK_CYC = ACK_US * 1000 / CLK_NS;
  localparam int SHAKE_CYC = SHAKE_US * 1000 / CLK_NS;
  localparam int ACT_CYC = ACT_NS / CLK_NS;
  localparam int ZERO_RUN = ACT_CYC / 2;
  localparam int CMD_BITS = 64;
  localparam int TMR_W = 19;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STAT = 12'h004;
  localparam logic [11:0] OFF_EVT = 12'h008;
  localparam int CTRL_CAP = 0;
  localparam int CTRL_DOZE = 1;
  localparam int CTRL_ROUSE = 2;
  localparam int CTRL_REJECT = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam int EV_SLP_RX = 0;
  localparam int EV_WUR_RX = 1;
  localparam int EV_WUP_RX = 2;
  localparam int EV_FAIL = 3;
  localparam int EV_SLP_TX = 4;
  localparam logic [4:0] EVT_RST = 5'h00;
  localparam logic [1:0] MODE_Z = 2'h0;
  localparam logic [1:0] MODE_I = 2'h1;
  localparam logic [1:0] MODE_N = 2'h2;
  typedef enum logic [2:0] {
    ST_NORMAL, ST_ACK_WAIT, ST_HANDSHAKE, ST_QUIET, ST_ABORT, ST_SLEEP
  } psw_state_e;
endpackage

// >>> sim/psw_link_partner.sv
`timescale 1ns/100ps
module psw_link_partner #(
  parameter int CMD_LEN = 64,
  parameter int PULSE_LEN = 30
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go_sleep,
  input wire logic go_rouse,
  input wire logic go_pulse,
  input wire logic silent,
  output logic rx_cmd_sleep,
  output logic rx_cmd_rouse,
  output logic rx_zero,
  output logic line_energy
);
  int slp_left;
  int rou_left;
  int pul_left;
  // A command run is always a full word, since this partner never aborts.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slp_left <= 0;
      rou_left <= 0;
      pul_left <= 0;
    end else begin
      slp_left <= go_sleep ? CMD_LEN : (slp_left > 0 ? slp_left - 1 : 0);
      rou_left <= go_rouse ? CMD_LEN : (rou_left > 0 ? rou_left - 1 : 0);
      pul_left <= go_pulse ? PULSE_LEN : (pul_left > 0 ? pul_left - 1 : 0);
    end
  end
  assign rx_cmd_sleep = slp_left > 0;
  assign rx_cmd_rouse = rou_left > 0;
  assign rx_zero = silent;
  assign line_energy = pul_left > 0;
endmodule // psw_link_partner

// >>> sim/phy_sleep_wake_control_bench.sv
`timescale 1ns/100ps
module phy_sleep_wake_control_bench;
  import psw_pkg::*;
  // Short timer counts keep the run brief.
  localparam int PCNT = 20;
  localparam int ACNT = 80;
  localparam int SCNT = 160;
  logic pclk = 0;
  logic presetn = 0;
  logic ce = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] sc = 2'h2;
  logic [1:0] tx_data = 2'h0;
  logic tx_enable = 0;
  logic [1:0] tx_mode = MODE_N;
  logic rx_zero, rx_cmd_sleep, rx_cmd_rouse, line_energy;
  logic [1:0] sd;
  logic wake_training_req, sleep_cmd_sending, sleep, inhibit;
  logic low_power_capable;
  logic go_sleep = 0, go_rouse = 0, go_pulse = 0, silent = 0;
  int err_total = 0;
  int cmp_count = 0;
  int n;
  logic [31:0] rd;
  logic er;

  always #25 pclk = ~pclk;

  psw_sleep_wake #(.PULSE_CNT(PCNT), .ACK_CNT(ACNT), .SHAKE_CNT(SCNT)) dut (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sc, .tx_data, .tx_enable, .tx_mode,
    .rx_zero, .rx_cmd_sleep, .rx_cmd_rouse, .line_energy, .sd,
    .wake_training_req, .sleep_cmd_sending, .sleep, .inhibit,
    .low_power_capable
  );

  psw_link_partner #(.CMD_LEN(CMD_BITS), .PULSE_LEN(PCNT + 10)) peer (
    .pclk, .presetn, .go_sleep, .go_rouse, .go_pulse, .silent,
    .rx_cmd_sleep, .rx_cmd_rouse, .rx_zero, .line_energy
  );

  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdm(input logic [11:0] a, input logic [31:0] m,
      input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd & m, exp);
  endtask

  // Counts cycles in which the wake-request bit is inverted on the line.
  task automatic cnt_inv(output int c);
    c = 0;
    repeat (100) begin
      tick(1);
      if (sd[0] !== sc[0]) c++;
    end
  endtask

  task automatic summarize();
    if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    tick(6000);
    err_total++;
    summarize();
  end

  initial begin
    tick(10);
    presetn <= 1'b1;
    tick(2);
    chk({28'h0, sleep, inhibit, low_power_capable, sleep_cmd_sending},
        32'h4);
    rdm(OFF_STAT, 32'h3f7, 32'h100);
    apb(1'b0, 12'h00c, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    apb(1'b1, OFF_CTRL, 32'h1);
    tick(1);
    chk({31'h0, low_power_capable}, 32'h1);
    rdm(OFF_CTRL, 32'h1, 32'h1);
    tx_data <= 2'h3;
    tx_enable <= 1'b1;
    tick(6);
    chk({30'h0, sd}, 32'h1);
    tx_enable <= 1'b0;
    tick(6);
    chk({30'h0, sd}, 32'h2);
    // Own sleep request with a silent partner must time out.
    apb(1'b1, OFF_CTRL, 32'h3);
    tick(4);
    chk({30'h0, sleep_cmd_sending, sd[1]}, 32'h2);
    rdm(OFF_EVT, 32'h10, 32'h0);
    rdm(OFF_STAT, 32'h107, 32'h102);
    tick(70);
    rdm(OFF_EVT, 32'h10, 32'h10);
    tick(SCNT);
    rdm(OFF_STAT, 32'h7, 32'h0);
    rdm(OFF_EVT, 32'h8, 32'h8);
    apb(1'b1, OFF_EVT, 32'h1f);
    // Remote sleep request rejected during the acknowledge wait.
    go_sleep <= 1'b1;
    tick(1);
    go_sleep <= 1'b0;
    tick(30);
    rdm(OFF_STAT, 32'h17, 32'h0);
    tick(40);
    rdm(OFF_STAT, 32'h17, 32'h11);
    apb(1'b1, OFF_CTRL, 32'h9);
    tick(2);
    rdm(OFF_STAT, 32'h7, 32'h0);
    // Remote sleep request accepted through to sleep.
    go_sleep <= 1'b1;
    tick(1);
    go_sleep <= 1'b0;
    tick(70);
    rdm(OFF_STAT, 32'h7, 32'h1);
    tick(40);
    rdm(OFF_STAT, 32'h7, 32'h1);
    for (n = 0; n < 400 && inhibit !== 1'b0; n++) tick(1);
    chk({31'h0, n > 64}, 32'h1);
    rdm(OFF_STAT, 32'h307, 32'h3);
    silent <= 1'b1;
    for (n = 0; n < 20 && sleep !== 1'b1; n++) tick(1);
    chk({31'h0, sleep}, 32'h1);
    rdm(OFF_STAT, 32'h407, 32'h5);
    go_pulse <= 1'b1;
    tick(1);
    go_pulse <= 1'b0;
    tick(10);
    chk({31'h0, sleep}, 32'h1);
    for (n = 0; n < 60 && sleep !== 1'b0; n++) tick(1);
    chk({31'h0, sleep}, 32'h0);
    silent <= 1'b0;
    rdm(OFF_EVT, 32'h4, 32'h4);
    // Wake request on an up link, a down link and a training link.
    apb(1'b1, OFF_CTRL, 32'h5);
    cnt_inv(n);
    chk({31'h0, n >= 64}, 32'h1);
    tx_mode <= MODE_Z;
    apb(1'b1, OFF_CTRL, 32'h5);
    n = 0;
    repeat (60) begin
      tick(1);
      if (wake_training_req === 1'b1) n++;
    end
    chk(n, PCNT);
    tx_mode <= MODE_I;
    apb(1'b1, OFF_CTRL, 32'h5);
    tick(10);
    chk({30'h0, sd[0] ^ sc[0], wake_training_req}, 32'h0);
    tx_mode <= MODE_N;
    cnt_inv(n);
    chk({31'h0, n >= 64}, 32'h1);
    go_rouse <= 1'b1;
    tick(1);
    go_rouse <= 1'b0;
    tick(70);
    rdm(OFF_EVT, 32'h2, 32'h2);
    // A wake request made in quiet is kept and ends the sleep at once.
    go_sleep <= 1'b1;
    tick(1);
    go_sleep <= 1'b0;
    for (n = 0; n < 400 && inhibit !== 1'b0; n++) tick(1);
    apb(1'b1, OFF_CTRL, 32'h5);
    rdm(OFF_STAT, 32'h807, 32'h803);
    silent <= 1'b1;
    for (n = 0; n < 20 && sleep !== 1'b1; n++) tick(1);
    chk({31'h0, sleep}, 32'h1);
    tick(2);
    rdm(OFF_STAT, 32'h7, 32'h0);
    silent <= 1'b0;
    // With the clock enable low a write must be lost.
    ce <= 1'b0;
    apb(1'b1, OFF_CTRL, 32'h0);
    ce <= 1'b1;
    tick(1);
    chk({31'h0, low_power_capable}, 32'h1);
    summarize();
  end
endmodule // phy_sleep_wake_control_bench
